// ### hw/wdtb_map.svh
`ifndef WDTB_MAP_SVH
`define WDTB_MAP_SVH

// register byte offsets, one aligned word each
`define WDTB_OFS_CTRL 8'h00
`define WDTB_OFS_STATUS 8'h04
`define WDTB_OFS_ICLR 8'h08
`define WDTB_OFS_IEN 8'h0C
`define WDTB_OFS_COUNT 8'h10

// control register field positions
`define WDTB_CTRL_ENABLE_BIT 7
`define WDTB_CTRL_RESTART_BIT 6
`define WDTB_CTRL_IDLE_RUN_BIT 3
`define WDTB_CTRL_SEL_MSB 2
`define WDTB_CTRL_SEL_LSB 0
`define WDTB_CTRL_WIDTH 8

// event bit positions of status, clear and enable registers
`define WDTB_EVT_EXPIRE_BIT 0
`define WDTB_EVT_WIDTH 1

// reset values
`define WDTB_CTRL_RESET 8'h00
`define WDTB_EVT_RESET 1'h0

// timing counts
`define WDTB_OSC_PER_MC 12
`define WDTB_TIMER_BITS 14
`define WDTB_PRESCALE_BITS 8

// bus encodings
`define WDTB_HTRANS_NONSEQ_BIT 1
`define WDTB_HSIZE_WORD 3'h2

`endif

// ### hw/wdtb_pkg.sv
`include "wdtb_map.svh"

package wdtb_pkg;

    // control register layout, msb first
    typedef struct packed {
        logic enable;
        logic restart;
        logic [1:0] rsvd;
        logic idle_run;
        logic [2:0] sel;
    } wdtb_ctrl_t;

    // what the divider chain needs from the register file
    typedef struct packed {
        logic run;
        logic clear;
        logic [2:0] sel;
    } wdtb_div_cfg_t;

    // latched address phase of one bus transfer
    typedef struct packed {
        logic write;
        logic read;
        logic word;
        logic [7:0] addr;
    } wdtb_addr_phase_t;

endpackage : wdtb_pkg

// ### hw/wdtb_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdtb_map.svh"

module wdtb_divider
    import wdtb_pkg::*;
#(
    parameter int MC_DIV = `WDTB_OSC_PER_MC,
    parameter int TIMER_W = `WDTB_TIMER_BITS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire wdtb_div_cfg_t cfg,
    output logic [TIMER_W-1:0] timer_value,
    output logic expire
);

    localparam int MC_W = $clog2(MC_DIV);
    localparam logic [MC_W-1:0] MC_LAST = MC_W'(MC_DIV - 1);

    logic [MC_W-1:0] mc_q;
    logic [`WDTB_PRESCALE_BITS-1:0] ps_q;
    logic [TIMER_W-1:0] timer_q;
    logic expire_q;
    logic mc_tick;
    logic ps_wrap;

    // last prescaler count for each select code
    function automatic logic [`WDTB_PRESCALE_BITS-1:0] ps_last(input logic [2:0] sel);
        logic [`WDTB_PRESCALE_BITS-1:0] r;
        r = 8'h01;
        unique case (sel)
            3'h0: r = 8'h01;
            3'h2: r = 8'h03;
            3'h1: r = 8'h07;
            3'h3: r = 8'h0F;
            3'h4: r = 8'h1F;
            3'h5: r = 8'h3F;
            3'h6: r = 8'h7F;
            3'h7: r = 8'hFF;
        endcase
        return r;
    endfunction : ps_last

    assign mc_tick = cfg.run && (mc_q == MC_LAST);
    // >= so that a smaller select taken mid-count still wraps at the next machine-cycle tick
    assign ps_wrap = mc_tick && (ps_q >= ps_last(cfg.sel));

    // machine cycle: twelve oscillator clocks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mc_q <= '0;
        end else if (cfg.clear) begin
            mc_q <= '0;
        end else if (cfg.run) begin
            mc_q <= mc_tick ? '0 : mc_q + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ps_q <= '0;
        end else if (cfg.clear) begin
            ps_q <= '0;
        end else if (mc_tick) begin
            ps_q <= ps_wrap ? '0 : ps_q + 1'b1;
        end
    end

    // timeout = 12 x ratio x 2^14 clocks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_q <= '0;
        end else if (cfg.clear) begin
            timer_q <= '0;
        end else if (ps_wrap) begin
            timer_q <= timer_q + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            expire_q <= 1'b0;
        end else begin
            expire_q <= !cfg.clear && ps_wrap && (&timer_q);
        end
    end

    assign timer_value = timer_q;
    assign expire = expire_q;

endmodule : wdtb_divider
`default_nettype wire

// ### hw/wdtb_top.sv
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "wdtb_map.svh"

module wdtb_top
    import wdtb_pkg::*;
#(
    parameter int MC_DIV = `WDTB_OSC_PER_MC,
    parameter int TIMER_W = `WDTB_TIMER_BITS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic idle_request_bit,
    output logic sys_reset_req,
    output logic irq
);

    wdtb_addr_phase_t aph_d;
    wdtb_addr_phase_t aph_q;
    wdtb_ctrl_t ctrl_q;
    wdtb_ctrl_t ctrl_wr;
    wdtb_div_cfg_t div_cfg;
    logic [`WDTB_EVT_WIDTH-1:0] status_q;
    logic [`WDTB_EVT_WIDTH-1:0] status_d;
    logic [`WDTB_EVT_WIDTH-1:0] ien_q;
    logic [`WDTB_EVT_WIDTH-1:0] ien_d;
    logic [`WDTB_EVT_WIDTH-1:0] evt_set;
    logic [`WDTB_EVT_WIDTH-1:0] evt_clr;
    logic [TIMER_W-1:0] timer_value;
    logic expire;
    logic take;
    logic wr_ctrl;
    logic wr_iclr;
    logic wr_ien;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic sys_reset_req_q;
    logic irq_q;

    // returns one when the offset selects the given register
    function automatic logic hits(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction : hits

    // ---------------- bus address phase ----------------

    assign take = hsel && hready && htrans[`WDTB_HTRANS_NONSEQ_BIT];

    always_comb begin
        aph_d = '0;
        if (take) begin
            aph_d.write = hwrite;
            aph_d.read = !hwrite;
            aph_d.word = (hsize == `WDTB_HSIZE_WORD);
            aph_d.addr = haddr[7:0];
        end
    end

    // only the address phase of an accepted transfer is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_q <= '0;
        end else if (hready) begin
            aph_q <= aph_d;
        end else begin
            aph_q <= '0;
        end
    end

    // ---------------- write data phase ----------------

    // sub-word writes are dropped: only whole words reach a register
    assign wr_ctrl = aph_q.write && aph_q.word && hits(aph_q.addr, `WDTB_OFS_CTRL);
    assign wr_iclr = aph_q.write && aph_q.word && hits(aph_q.addr, `WDTB_OFS_ICLR);
    assign wr_ien = aph_q.write && aph_q.word && hits(aph_q.addr, `WDTB_OFS_IEN);

    assign ctrl_wr = wdtb_ctrl_t'(hwdata[`WDTB_CTRL_WIDTH-1:0]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q.enable <= 1'b0;
            ctrl_q.idle_run <= 1'b0;
            ctrl_q.sel <= 3'h0;
            ctrl_q.rsvd <= 2'h0;
        end else if (wr_ctrl) begin
            ctrl_q.enable <= ctrl_wr.enable;
            ctrl_q.idle_run <= ctrl_wr.idle_run;
            ctrl_q.sel <= ctrl_wr.sel;
            ctrl_q.rsvd <= 2'h0;
        end
    end

    // restart bit: software sets, hardware clears one clock later;
    // a new set in the clearing cycle wins so no restart is lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q.restart <= 1'b0;
        end else if (wr_ctrl && ctrl_wr.restart) begin
            ctrl_q.restart <= 1'b1;
        end else if (ctrl_q.restart) begin
            ctrl_q.restart <= 1'b0;
        end
    end

    // ---------------- divider chain ----------------

    // idle stops the cpu; counting continues only if idle-run is set
    always_comb begin
        div_cfg.run = ctrl_q.enable && (!idle_request_bit || ctrl_q.idle_run);
        div_cfg.clear = ctrl_q.restart;
        div_cfg.sel = ctrl_q.sel;
    end

    wdtb_divider #(
        .MC_DIV(MC_DIV),
        .TIMER_W(TIMER_W)
    ) u_divider (
        .hclk(hclk),
        .hresetn(hresetn),
        .cfg(div_cfg),
        .timer_value(timer_value),
        .expire(expire)
    );

    // one-cycle request; the system reset that follows resets this block too
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_reset_req_q <= 1'b0;
        end else begin
            sys_reset_req_q <= expire && ctrl_q.enable;
        end
    end

    // ---------------- interrupt ----------------

    always_comb begin
        evt_set = '0;
        evt_set[`WDTB_EVT_EXPIRE_BIT] = expire && ctrl_q.enable;
        evt_clr = wr_iclr ? hwdata[`WDTB_EVT_WIDTH-1:0] : '0;
        status_d = (status_q & ~evt_clr) | evt_set;
        ien_d = wr_ien ? hwdata[`WDTB_EVT_WIDTH-1:0] : ien_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= `WDTB_EVT_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ien_q <= `WDTB_EVT_RESET;
        end else begin
            ien_q <= ien_d;
        end
    end

    // built from next values so the line follows the status bits directly
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_d & ien_d);
        end
    end

    // ---------------- read data phase ----------------

    // one wait state on reads: ready drops right after the address edge,
    // so the data phase cannot end before the registered read data stands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
        end else if (take && !hwrite) begin
            hreadyout_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
        end
    end

    // loaded at the edge that ends the wait state; a write just before is visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (aph_q.read) begin
            hrdata_q <= 32'h00000000;
            if (hits(aph_q.addr, `WDTB_OFS_CTRL)) begin
                hrdata_q[`WDTB_CTRL_WIDTH-1:0] <= ctrl_q;
            end else if (hits(aph_q.addr, `WDTB_OFS_STATUS)) begin
                hrdata_q[`WDTB_EVT_WIDTH-1:0] <= status_q;
            end else if (hits(aph_q.addr, `WDTB_OFS_IEN)) begin
                hrdata_q[`WDTB_EVT_WIDTH-1:0] <= ien_q;
            end else if (hits(aph_q.addr, `WDTB_OFS_COUNT)) begin
                hrdata_q[TIMER_W-1:0] <= timer_value;
            end
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;
    assign sys_reset_req = sys_reset_req_q;
    assign irq = irq_q;

endmodule : wdtb_top
`default_nettype wire

// ### tb/wdtb_props.sv
`timescale 1ns/1ps
`default_nettype none
module wdtb_props #(
    parameter int MC_DIV = 12,
    parameter int TIMER_W = 14
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic idle_request_bit,
    input wire logic sys_reset_req,
    input wire logic irq
);
    logic take;
    logic wctl_q;
    logic en_q;
    logic run_q;
    logic rz_q;
    assign take = hsel && hready && htrans[1];
    // shadow of enable and idle-run, taken from control writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wctl_q <= 1'b0;
            en_q <= 1'b0;
            run_q <= 1'b0;
            rz_q <= 1'b0;
        end else begin
            wctl_q <= take && hwrite && haddr[7:0] == 8'h00 && hsize == 3'h2;
            if (wctl_q) begin
                en_q <= hwdata[7];
                run_q <= hwdata[3];
            end
            if (take && !hwrite) begin
                rz_q <= haddr[7:0] > 8'h10 || haddr[7:0] == 8'h08 || haddr[1:0] != 2'h0;
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
    a_pulse_single: assert property (sys_reset_req |=> !sys_reset_req) else $error("reset pulse too long");
    a_rdata_hold: assert property (!$rose(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
    a_unmapped_zero: assert property ($rose(hreadyout) && rz_q |-> hrdata == 32'h0) else $error("unmapped read");
    // three cycles of margin cover the pulse pipeline
    a_off_no_reset: assert property (!en_q && !$past(en_q) && !$past(en_q, 2) && !$past(en_q, 3)
        |-> !sys_reset_req) else $error("reset while disabled");
    a_idle_hold: assert property (idle_request_bit && $past(idle_request_bit) && $past(idle_request_bit, 3)
        && !run_q && !$past(run_q, 3) |-> !sys_reset_req) else $error("reset in idle");
    cover property (sys_reset_req);
    cover property ($rose(irq));
    cover property ($rose(hreadyout) && rz_q);
endmodule : wdtb_props
bind wdtb_top wdtb_props #(.MC_DIV(MC_DIV), .TIMER_W(TIMER_W)) wdtb_props_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .idle_request_bit(idle_request_bit), .sys_reset_req(sys_reset_req), .irq(irq));
`default_nettype wire

// ### tb/watchdog_timer_block_tb.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_block_tb;
    localparam int MC = 2;
    localparam int TW = 4;
    logic hclk, hresetn, hsel, hwrite, hready, idle_request_bit;
    logic [31:0] haddr, hwdata, hrdata, v, w;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, sys_reset_req, irq;
    int fail_count = 0, check_count = 0, pc = 0, p0, n;
    int rat[8] = '{2, 8, 4, 16, 32, 64, 128, 256};
    assign hready = hreadyout;
    wdtb_top #(.MC_DIV(MC), .TIMER_W(TW)) wdtb_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .idle_request_bit(idle_request_bit),
        .sys_reset_req(sys_reset_req), .irq(irq));
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) if (sys_reset_req === 1'b1) pc++;
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // counts edges up to the next expiry pulse, bounded
    task automatic wp(output int k);
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (sys_reset_req !== 1'b1 && k < 20000);
    endtask : wp
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    initial begin
        #(8 * 90000);
        fail_count++;
        end_of_test();
    end
    initial begin
        {hsel, hwrite, idle_request_bit, haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        hresetn = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        @(posedge hclk);
        for (int a = 0; a <= 20; a += 4) begin
            xfer(1'b0, a[7:0], 32'h0, v);
            chk("reset read", 32'h0, v);
        end
        chk("irq", 32'h0, {31'h0, irq});
        $display("test reset done");
        wr(8'h00, 32'h80);
        repeat (50) @(posedge hclk);
        xfer(1'b0, 8'h10, 32'h0, v);
        chk("count runs", 32'h1, {31'h0, v !== 32'h0});
        wr(8'h00, 32'h00);
        xfer(1'b0, 8'h10, 32'h0, v);
        repeat (50) @(posedge hclk);
        xfer(1'b0, 8'h10, 32'h0, w);
        chk("count frozen", v, w);
        wr(8'h00, 32'h87);
        wr(8'h00, 32'hC7);
        xfer(1'b0, 8'h00, 32'h0, v);
        chk("restart clears", 32'h87, v);
        xfer(1'b0, 8'h10, 32'h0, v);
        chk("count cleared", 32'h0, v);
        $display("test enable done");
        idle_request_bit <= 1'b1;
        p0 = pc;
        wr(8'h00, 32'hC0);
        repeat (150) @(posedge hclk);
        xfer(1'b0, 8'h10, 32'h0, v);
        chk("idle count", 32'h0, v);
        chk("idle pulses", p0, pc);
        wr(8'h00, 32'hC8);
        wp(n);
        chk("idle run", 32'h1, {31'h0, n <= 80});
        idle_request_bit <= 1'b0;
        $display("test idle done");
        wp(n);
        xfer(1'b0, 8'h04, 32'h0, v);
        chk("status", 32'h1, v);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'h0C, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(8'h08, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq off", 32'h0, {31'h0, irq});
        xfer(1'b0, 8'h04, 32'h0, v);
        chk("status clear", 32'h0, v);
        $display("test irq done");
        p0 = pc;
        repeat (5) begin
            repeat (40) @(posedge hclk);
            wr(8'h00, 32'hC0);
        end
        chk("kept alive", p0, pc);
        for (int s = 0; s < 8; s++) begin
            wr(8'h00, 32'hC0 | s);
            wp(n);
            wp(n);
            chk("period", MC * rat[s] * (1 << TW), n);
        end
        $display("test ratios done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        p0 = pc;
        xfer(1'b0, 8'h00, 32'h0, v);
        chk("ctrl after reset", 32'h0, v);
        xfer(1'b0, 8'h10, 32'h0, v);
        chk("count after reset", 32'h0, v);
        repeat (200) @(posedge hclk);
        chk("no pulse", p0, pc);
        $display("test midreset done");
        end_of_test();
    end
endmodule : watchdog_timer_block_tb
`default_nettype wire
